// ===== design/cfg_status_regs.svh
// register offsets, field positions and reset values for the status and command register
`ifndef CFG_STATUS_REGS_SVH
`define CFG_STATUS_REGS_SVH

`define DEV_STAT_CMD_OFFSET 8'hF8
`define DEV_STAT_CMD_RESET 8'h00
`define BIT_CFG_ACTIVE 0
`define BIT_IF_RESET 1
`define RSVD_MASK 8'hFC
`define RELOAD_CYCLES 4'h4

`endif

// ===== design/cfg_status_pkg.sv
// types shared by the status and command register files
package cfg_status_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RELOAD,
        ST_DONE
    } reload_state_t;
endpackage

// ===== design/reload_if.sv
// handshake between the register bank and the reload sequencer
`timescale 1ns/1ps
`default_nettype none
interface reload_if;
    logic start; // one-cycle request to reload
    logic busy; // reload in progress
    logic load; // pulse: registers take reset values
    modport bank (output start, input busy, input load);
    modport seq (input start, output busy, output load);
endinterface
`default_nettype wire

// ===== design/reload_seq.sv
// sequencer that runs the register reload after an interface reset command
`timescale 1ns/1ps
`default_nettype none
`include "cfg_status_regs.svh"
module reload_seq (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // handshake
    reload_if.seq rl
);
    // ****************************************
    // reload state machine
    // ****************************************
    cfg_status_pkg::reload_state_t state_r; // current state
    cfg_status_pkg::reload_state_t state_nxt; // next state
    logic [3:0] cnt_r; // reload cycle counter
    logic [3:0] cnt_nxt;

    // next state and count
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            cfg_status_pkg::ST_IDLE: begin
                if (rl.start) begin
                    state_nxt = cfg_status_pkg::ST_RELOAD;
                    cnt_nxt = `RELOAD_CYCLES;
                end
            end
            cfg_status_pkg::ST_RELOAD: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = cfg_status_pkg::ST_DONE;
                end
            end
            cfg_status_pkg::ST_DONE: begin
                state_nxt = cfg_status_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = cfg_status_pkg::ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cfg_status_pkg::ST_IDLE;
            cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // busy spans reload and done; load fires in the done cycle
    assign rl.busy = (state_r != cfg_status_pkg::ST_IDLE);
    assign rl.load = (state_r == cfg_status_pkg::ST_DONE);
endmodule
`default_nettype wire

// ===== design/config_session_status_command.sv
// status and command register for the configuration session
//
// Functional notes
// R1: reserved bits 7:2 read zero, unwritable
// R2: writing one to reset reloads all registers
// R3: reset bit reads one until reload completes
// R4: writing zero to reset bit does nothing
// R5: session bit sets on entering serial config
// R6: upstream connect held off while session active
// R7: host clears session bit to allow connect
// R8: write one clears session bit; zero ignored
//
// the connect output is registered from the next flag value, so it moves
// on the same edge as the session flag
// a reset command written while a reload runs is dropped, not queued
// the reload returns the session flag to its reset value, even when
// serial configuration entry is signalled in that same cycle
`timescale 1ns/1ps
`default_nettype none
`include "cfg_status_regs.svh"
module config_session_status_command (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register access from the serial management slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // configuration mode entry
    input wire logic serial_cfg_enter,
    // status to the rest of the device
    output logic upstream_connect_allow,
    output logic regs_reload
);
    // ****************************************
    // decode
    // ****************************************
    logic config_session_active_r; // session flag
    logic interface_reset_cmd_r; // reset command flag
    logic sel; // address hits the register
    logic wr_hit; // write to the register
    logic start_reset; // new reset requested
    logic clr_session; // write one to session bit
    logic session_nxt;
    logic rst_cmd_nxt;
    logic [7:0] reg_val; // assembled read value
    reload_if rl (); // bank to sequencer handshake
    // reset image of the register, source of the session flag's reload value
    localparam logic [7:0] reg_reset_val = `DEV_STAT_CMD_RESET;

    // ****************************************
    // write decode
    // ****************************************
    // a write to this register carrying a one at one bit position
    function automatic logic wrote_one(input logic hit, input logic [7:0] data, input int pos);
        return hit && data[pos];
    endfunction

    // address match, shared by the read and write paths
    assign sel = (reg_addr == `DEV_STAT_CMD_OFFSET);
    // write strobe qualified by the address
    assign wr_hit = reg_wr && sel;
    // a one starts a reload only from idle; a repeat while busy is dropped
    assign start_reset = wrote_one(wr_hit, reg_wdata, `BIT_IF_RESET) && !interface_reset_cmd_r; // R2 R4
    // a one ends the session; a zero leaves it
    assign clr_session = wrote_one(wr_hit, reg_wdata, `BIT_CFG_ACTIVE); // R8 R7
    assign rl.start = start_reset;
    // reserved bits forced to zero
    assign reg_val = {6'h00, interface_reset_cmd_r, config_session_active_r} & ~`RSVD_MASK; // R1

    // reload sequencer
    reload_seq i_reload_seq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rl(rl)
    );

    // ****************************************
    // flag next values
    // ****************************************
    // entry sets win over clear; reload returns reset value
    assign session_nxt = rl.load ? reg_reset_val[`BIT_CFG_ACTIVE] :
                         serial_cfg_enter ? 1'b1 : // R5
                         clr_session ? 1'b0 : config_session_active_r; // R8
    // reset bit holds until the reload is done
    assign rst_cmd_nxt = start_reset ? 1'b1 : // R2
                         rl.load ? 1'b0 : interface_reset_cmd_r; // R3

    // flag registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_session_active_r <= 1'b0;
            interface_reset_cmd_r <= 1'b0;
        end else begin
            config_session_active_r <= session_nxt;
            interface_reset_cmd_r <= rst_cmd_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // registered read data and status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            upstream_connect_allow <= 1'b0;
            regs_reload <= 1'b0;
        end else begin
            reg_rdata <= (reg_rd && sel) ? reg_val : 8'h00;
            upstream_connect_allow <= !session_nxt; // R6
            regs_reload <= rl.load; // R2
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // read data never shows the reserved bits
    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (!rst_n) reg_rdata[7:2] == 6'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero"); // R1

    // the internal load lands a fixed time after the command
    property p_reset_reload;
        @(posedge clk_sys) disable iff (!rst_n) start_reset |-> ##5 rl.load;
    endproperty
    a_reset_reload: assert property (p_reset_reload) else $error("reload not done"); // R2

    // command bit stays up for the whole reload, then drops
    property p_reset_holds;
        @(posedge clk_sys) disable iff (!rst_n) start_reset |=> interface_reset_cmd_r [*5] ##1 !interface_reset_cmd_r;
    endproperty
    a_reset_holds: assert property (p_reset_holds) else $error("reset bit timing wrong"); // R3

    // a zero in the command bit starts nothing
    property p_zero_no_reset;
        @(posedge clk_sys) disable iff (!rst_n)
            (wr_hit && !reg_wdata[`BIT_IF_RESET] && !interface_reset_cmd_r) |=> !interface_reset_cmd_r;
    endproperty
    a_zero_no_reset: assert property (p_zero_no_reset) else $error("zero write started reset"); // R4

    // entry into serial configuration raises the session flag
    property p_enter_sets;
        @(posedge clk_sys) disable iff (!rst_n) serial_cfg_enter && !rl.load |=> config_session_active_r;
    endproperty
    a_enter_sets: assert property (p_enter_sets) else $error("session not set"); // R5

    // no upstream connect while the session is open
    property p_hold_connect;
        @(posedge clk_sys) disable iff (!rst_n) config_session_active_r |-> !upstream_connect_allow;
    endproperty
    a_hold_connect: assert property (p_hold_connect) else $error("connect while active"); // R6

    // a one clears the flag and opens the connect path together
    property p_clear_one;
        @(posedge clk_sys) disable iff (!rst_n)
            clr_session && !serial_cfg_enter |=> !config_session_active_r ##0 upstream_connect_allow;
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("session not cleared"); // R8

    // a zero leaves an open session alone
    property p_clear_zero;
        @(posedge clk_sys) disable iff (!rst_n)
            wr_hit && !reg_wdata[`BIT_CFG_ACTIVE] && !rl.load && config_session_active_r |=> config_session_active_r;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared session"); // R8

    // sequencer busy and the command bit must agree every cycle
    property p_busy_track;
        @(posedge clk_sys) disable iff (!rst_n) rl.busy == interface_reset_cmd_r;
    endproperty
    a_busy_track: assert property (p_busy_track) else $error("busy and reset bit disagree"); // R3

    // the reload strobe to the other registers lasts one cycle
    property p_reload_pulse;
        @(posedge clk_sys) disable iff (!rst_n) regs_reload |=> !regs_reload;
    endproperty
    a_reload_pulse: assert property (p_reload_pulse) else $error("reload strobe too long"); // R2

    // the load strobes the others and returns both flags to reset values
    property p_reload_clears;
        @(posedge clk_sys) disable iff (!rst_n)
            rl.load |=> regs_reload && !interface_reset_cmd_r && !config_session_active_r;
    endproperty
    a_reload_clears: assert property (p_reload_clears) else $error("reload left state behind"); // R2

    // entry in the same cycle as a clearing write keeps the session open
    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_n) serial_cfg_enter && clr_session && !rl.load |=> config_session_active_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat entry"); // R5

    // a read returns both flags as they stood when it was taken
    property p_read_value;
        @(posedge clk_sys) disable iff (!rst_n) reg_rd && sel |=>
            reg_rdata[`BIT_IF_RESET] == $past(interface_reset_cmd_r) &&
            reg_rdata[`BIT_CFG_ACTIVE] == $past(config_session_active_r);
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data wrong"); // R3

    // reads elsewhere, and idle cycles, return zero
    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!rst_n) !(reg_rd && sel) |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero"); // R1

    // ****************************************
    // covers
    // ****************************************
    c_reset: cover property (@(posedge clk_sys) disable iff (!rst_n) start_reset ##5 rl.load);
    c_session: cover property (@(posedge clk_sys) disable iff (!rst_n) serial_cfg_enter ##[1:20] clr_session);
    c_connect: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(upstream_connect_allow));
    // entry and clear written in the same cycle
    c_set_wins: cover property (@(posedge clk_sys) disable iff (!rst_n) serial_cfg_enter && clr_session);
    // a second reset command refused while one runs
    c_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
        wr_hit && reg_wdata[`BIT_IF_RESET] && interface_reset_cmd_r);
endmodule
`default_nettype wire

// ===== tb/mgmt_host.sv
// management host model driving the register port of the status block
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // lines start quiet
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write, released after the taking edge; idle lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read, data taken in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    // closes the session so the upstream port may connect
    task automatic end_session();
        wr(8'hF8, 8'h01);
    endtask
endmodule
`default_nettype wire

// ===== tb/test_config_session_status_command.sv
// self-checking bench for the session status and command register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_config_session_status_command;
    // ********************
    // signals
    // ********************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic serial_cfg_enter = 1'b0;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic upstream_connect_allow;
    logic regs_reload;
    logic [7:0] d;
    logic seen;
    int cyc = 0;
    int t0;
    int n_mismatch = 0;
    int cmp_count = 0;
    // device and host
    config_session_status_command i_config_session_status_command (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .serial_cfg_enter(serial_cfg_enter), .upstream_connect_allow(upstream_connect_allow),
        .regs_reload(regs_reload));
    mgmt_host i_mgmt_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // clock at 40 ns
    always #20 clk_sys = ~clk_sys;
    // cycle count and hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
    // counts, verdict, end of run
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one-cycle entry into serial configuration
    task automatic enter_cfg();
        @(posedge clk_sys);
        serial_cfg_enter <= 1'b1;
        @(posedge clk_sys);
        serial_cfg_enter <= 1'b0;
        #1;
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        i_mgmt_host.rd(8'hF8, d);
        `CHK("reset value", 8'h00, d)
        `CHK("connect idle", 1'b1, upstream_connect_allow)
        i_mgmt_host.wr(8'hF8, 8'hFC);
        i_mgmt_host.rd(8'hF8, d);
        `CHK("reserved", 8'h00, d)
        enter_cfg();
        `CHK("connect held", 1'b0, upstream_connect_allow)
        i_mgmt_host.rd(8'hF8, d);
        `CHK("session set", 8'h01, d)
        i_mgmt_host.wr(8'hF8, 8'h00);
        i_mgmt_host.rd(8'hF8, d);
        `CHK("zero write", 8'h01, d)
        i_mgmt_host.end_session();
        i_mgmt_host.rd(8'hF8, d);
        `CHK("session clear", 8'h00, d)
        `CHK("connect open", 1'b1, upstream_connect_allow)
        // entry held across a clearing write: entry wins
        @(posedge clk_sys);
        serial_cfg_enter <= 1'b1;
        i_mgmt_host.wr(8'hF8, 8'h01);
        serial_cfg_enter <= 1'b0;
        i_mgmt_host.rd(8'hF8, d);
        `CHK("entry beats clear", 8'h01, d)
        `CHK("connect held again", 1'b0, upstream_connect_allow)
        i_mgmt_host.end_session();
        seen = 1'b0;
        i_mgmt_host.wr(8'hF8, 8'h00);
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            if (regs_reload === 1'b1)
                seen = 1'b1;
        end
        `CHK("no reload", 1'b0, seen)
        enter_cfg();
        i_mgmt_host.wr(8'hF8, 8'h02);
        #1;
        t0 = cyc;
        // a second one while the reload runs is refused
        i_mgmt_host.wr(8'hF8, 8'h02);
        i_mgmt_host.rd(8'hF8, d);
        `CHK("reset bit", 8'h03, d)
        for (int i = 0; i < 20 && regs_reload !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        // four reload counts plus the done state after the taking edge
        `CHK("reload delay", 5, cyc - t0)
        @(posedge clk_sys);
        #1;
        `CHK("reload pulse", 1'b0, regs_reload)
        i_mgmt_host.rd(8'hF8, d);
        `CHK("after reload", 8'h00, d)
        `CHK("connect reload", 1'b1, upstream_connect_allow)
        i_mgmt_host.rd(8'hF0, d);
        `CHK("unmapped", 8'h00, d)
        // mid-run reset with a session open
        enter_cfg();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("connect in reset", 1'b0, upstream_connect_allow)
        @(posedge clk_sys);
        rst_n <= 1'b1;
        i_mgmt_host.rd(8'hF8, d);
        `CHK("reset clears", 8'h00, d)
        `CHK("connect after reset", 1'b1, upstream_connect_allow)
        results();
    end
endmodule
`default_nettype wire
